//--- hdl/file_register_alu_ops.sv
// execution datapath for file-register ops, return and sleep
`timescale 1ns/100ps
`default_nettype none
`include "file_register_alu_regs.svh"
module file_register_alu_ops (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // instruction issue, one per instruction cycle
  input wire logic opValid,
  input wire file_register_alu_pkg::op_t op,
  input wire logic [6:0] fileAddr,
  input wire logic destBit,
  input wire logic [7:0] literal,
  input wire logic [7:0] fileRdData,
  // stack and wake-up
  input wire logic [12:0] stackHead,
  input wire logic wakeUp,
  // accumulator and file write port
  output logic [7:0] accR,
  output logic fileWrEnR,
  output logic [6:0] fileWrAddrR,
  output logic [7:0] fileWrDataR,
  // status flags
  output logic carryR,
  output logic halfByteOverflowR,
  output logic zeroR,
  output logic powerdownFlagR,
  output logic timeoutFlagR,
  // program counter, stack and watchdog
  output logic pcLoadR,
  output logic [12:0] pcValueR,
  output logic stackPopR,
  output logic watchdogClearR,
  output logic [7:0] watchdogCountR,
  output logic prescalerClearR,
  // core state
  output logic busyR,
  output logic asleepR
);
  file_register_alu_pkg::state_t stateR, stateNxt;
  logic [7:0] aluResult;
  logic aluCarry, aluHalf, aluZero;
  logic updCarry, updHalf, updZero;
  logic accept, isAlu, isReturn, isSleep, toFile, toAcc;

  file_alu_core i_file_alu_core (
    .op(op),
    .acc(accR),
    .fileVal(fileRdData),
    .literal(literal),
    .carryIn(carryR),
    .result(aluResult),
    .carryOut(aluCarry),
    .halfOut(aluHalf),
    .zeroOut(aluZero),
    .updCarry(updCarry),
    .updHalf(updHalf),
    .updZero(updZero)
  );

  // ops offered while busy or asleep are dropped; issue logic must hold them
  assign accept = opValid && (stateR == file_register_alu_pkg::ST_RUN);
  assign isReturn = accept &&
                    (op == file_register_alu_pkg::OP_SUBROUTINE_RETURN);
  assign isSleep = accept && (op == file_register_alu_pkg::OP_SLEEP);
  assign isAlu = accept && !isReturn && !isSleep;
  // the literal subtraction has no file operand, so it always lands in acc
  assign toFile = isAlu && (destBit == `DEST_FILE) &&
                  (op != file_register_alu_pkg::OP_LITERAL_MINUS_ACC); // RL1
  assign toAcc = isAlu && !toFile; // RL1 RL6

  always_comb begin
    stateNxt = stateR;
    case (stateR)
      file_register_alu_pkg::ST_RUN: begin
        if (isReturn)
          stateNxt = file_register_alu_pkg::ST_RETURN_TAIL; // RL8
        else if (isSleep)
          stateNxt = file_register_alu_pkg::ST_ASLEEP; // RL11
      end
      file_register_alu_pkg::ST_RETURN_TAIL: begin
        stateNxt = file_register_alu_pkg::ST_RUN; // RL8
      end
      file_register_alu_pkg::ST_ASLEEP: begin
        if (wakeUp)
          stateNxt = file_register_alu_pkg::ST_RUN; // RL11
      end
      default: begin
        stateNxt = file_register_alu_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stateR <= file_register_alu_pkg::ST_RUN;
      busyR <= 1'b0;
      asleepR <= 1'b0;
    end else begin
      stateR <= stateNxt;
      busyR <= (stateNxt != file_register_alu_pkg::ST_RUN);
      asleepR <= (stateNxt == file_register_alu_pkg::ST_ASLEEP);
    end
  end

  // result and flags commit on the same edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      accR <= `ACC_RESET;
      fileWrEnR <= 1'b0;
      fileWrAddrR <= 7'h00;
      fileWrDataR <= 8'h00;
    end else begin
      fileWrEnR <= toFile; // RL1 RL13
      if (toAcc)
        accR <= aluResult; // RL1 RL13
      if (toFile) begin
        fileWrAddrR <= fileAddr & `FILE_ADDR_MAX; // RL2
        fileWrDataR <= aluResult;
      end
    end
  end

  // return and sleep never touch carry, digit carry or zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      carryR <= `FLAG_RESET;
      halfByteOverflowR <= `FLAG_RESET;
      zeroR <= `FLAG_RESET;
    end else if (isAlu) begin
      if (updCarry)
        carryR <= aluCarry; // RL4 RL5 RL12 RL13
      if (updHalf)
        halfByteOverflowR <= aluHalf; // RL12
      if (updZero)
        zeroR <= aluZero; // RL2 RL3 RL6 RL7
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      powerdownFlagR <= `POWERDOWN_RESET;
      timeoutFlagR <= `TIMEOUT_RESET;
      watchdogClearR <= 1'b0;
      prescalerClearR <= 1'b0;
      watchdogCountR <= `WATCHDOG_CLEAR_VALUE;
      pcLoadR <= 1'b0;
      stackPopR <= 1'b0;
      pcValueR <= `PC_RESET;
    end else begin
      watchdogClearR <= isSleep; // RL9
      prescalerClearR <= isSleep; // RL9
      pcLoadR <= isReturn; // RL8
      stackPopR <= isReturn; // RL8
      if (isSleep) begin
        powerdownFlagR <= 1'b0; // RL10
        timeoutFlagR <= 1'b1; // RL10
        watchdogCountR <= `WATCHDOG_CLEAR_VALUE; // RL9
      end
      if (isReturn)
        pcValueR <= stackHead; // RL8
    end
  end

  // checks
  a_inc_result: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_INCREMENT_FILE
    |=> (($past(toFile) ? fileWrDataR : accR) ==
         8'($past(fileRdData) + `BYTE_ONE)) && carryR == $past(carryR))
    else $error("increment result or carry wrong"); // RL2
  a_or_result: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_OR_INTO_FILE
    |=> (($past(toFile) ? fileWrDataR : accR) ==
         ($past(accR) | $past(fileRdData)))
        && zeroR == (($past(accR) | $past(fileRdData)) == 8'h00))
    else $error("or result or zero wrong"); // RL3
  a_dest_route: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && destBit == `DEST_ACC |=> !fileWrEnR)
    else $error("acc destination wrote the file"); // RL1
  a_rot_left: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_ROTATE_LEFT_CARRY
    |=> carryR == $past(fileRdData[7]) &&
        (($past(toFile) ? fileWrDataR : accR) ==
         {$past(fileRdData[6:0]), $past(carryR)}))
    else $error("rotate left wrong"); // RL4
  a_rot_right: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY
    |=> carryR == $past(fileRdData[0]) &&
        (($past(toFile) ? fileWrDataR : accR) ==
         {$past(carryR), $past(fileRdData[7:1])}))
    else $error("rotate right wrong"); // RL5
  a_lit_sub: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_LITERAL_MINUS_ACC
    |=> accR == 8'($past(literal) - $past(accR)) &&
        carryR == ($past(literal) >= $past(accR)) && !fileWrEnR)
    else $error("literal subtract wrong"); // RL6
  a_file_sub: assert property (@(posedge mclk) disable iff (!rstn)
    isAlu && op == file_register_alu_pkg::OP_FILE_MINUS_ACC
    |=> halfByteOverflowR == ($past(fileRdData[3:0]) >= $past(accR[3:0]))
        && carryR == ($past(fileRdData) >= $past(accR)))
    else $error("file subtract flags wrong"); // RL7
  a_ret_cycles: assert property (@(posedge mclk) disable iff (!rstn)
    isReturn |=> pcLoadR && pcValueR == $past(stackHead) && busyR
    && $stable(carryR) && $stable(zeroR) ##1 !busyR && !pcLoadR)
    else $error("return timing or flags wrong"); // RL8
  a_sleep_flags: assert property (@(posedge mclk) disable iff (!rstn)
    isSleep |=> !powerdownFlagR && timeoutFlagR && watchdogClearR &&
    prescalerClearR && watchdogCountR == `WATCHDOG_CLEAR_VALUE &&
    $stable(carryR) && $stable(zeroR) && $stable(halfByteOverflowR))
    else $error("sleep status wrong"); // RL9
  a_asleep_idle: assert property (@(posedge mclk) disable iff (!rstn)
    asleepR && !wakeUp |=> $stable(accR) && !fileWrEnR && asleepR)
    else $error("activity while asleep"); // RL11
  a_sleep_only: assert property (@(posedge mclk) disable iff (!rstn)
    isSleep |=> $stable(halfByteOverflowR) ##1 powerdownFlagR == 1'b0)
    else $error("sleep touched other status"); // RL10
  c_return: cover property (@(posedge mclk) isReturn ##2 opValid);
  c_sleep_wake: cover property (@(posedge mclk) isSleep ##[1:20] wakeUp);
  c_file_write: cover property (@(posedge mclk) toFile);
  c_sub_borrow: cover property (@(posedge mclk)
    isAlu && op == file_register_alu_pkg::OP_FILE_MINUS_ACC ##1 !carryR);
endmodule // file_register_alu_ops
`default_nettype wire

//--- hdl/file_register_alu_regs.svh
// register constants and reset values for the file-register datapath
// Functional notes
// [RL1] A destination bit of 0 sends the result to the accumulator, 1 sends it back to the file register.
// [RL2] Increment adds one to the addressed file register (address 0 to 127), routes it by destination and changes only zero.
// [RL3] Inclusive OR of accumulator and file register is routed by destination and changes only zero.
// [RL4] Rotate left through carry: old carry enters bit 0, old bit 7 becomes carry.
// [RL5] Rotate right through carry: old carry enters bit 7, old bit 0 becomes carry.
// [RL6] Literal minus accumulator goes to the accumulator and updates carry, digit carry and zero.
// [RL7] File minus accumulator is routed by destination and updates carry, digit carry and zero.
// [RL8] Return pops the stack, loads stack head into the program counter, keeps all flags and takes two cycles.
// [RL9] Sleep clears the watchdog counter to 00h and clears its prescaler.
// [RL10] Sleep clears the powerdown flag, sets the timeout flag and changes no other status bit.
// [RL11] After sleep no instruction cycle runs until a wake-up.
// [RL12] In subtraction carry means no borrow and digit carry means no borrow out of the low nibble.
// [RL13] Arithmetic, logic and rotate finish in one cycle with result and flags written together.
`ifndef FILE_REGISTER_ALU_REGS_SVH
`define FILE_REGISTER_ALU_REGS_SVH
`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0
`define POWERDOWN_RESET 1'b1
`define TIMEOUT_RESET 1'b1
`define WATCHDOG_CLEAR_VALUE 8'h00
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define FILE_ADDR_MAX 7'h7F
`define BYTE_ONE 8'h01
`define PC_RESET 13'h0000
`define MSB_POS 7
`define NIBBLE_CARRY_POS 4
`define BYTE_CARRY_POS 8
`endif

//--- hdl/file_register_alu_pkg.sv
// types shared by the file-register datapath
package file_register_alu_pkg;
  typedef enum logic [2:0] {
    OP_INCREMENT_FILE,
    OP_OR_INTO_FILE,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_LITERAL_MINUS_ACC,
    OP_FILE_MINUS_ACC,
    OP_SUBROUTINE_RETURN,
    OP_SLEEP
  } op_t;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_RETURN_TAIL,
    ST_ASLEEP
  } state_t;
endpackage

//--- hdl/file_alu_core.sv
// combinational result and flag logic for one instruction
`timescale 1ns/100ps
`default_nettype none
`include "file_register_alu_regs.svh"
module file_alu_core (
  // operation and operands
  input wire file_register_alu_pkg::op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fileVal,
  input wire logic [7:0] literal,
  input wire logic carryIn,
  // result and flags
  output logic [7:0] result,
  output logic carryOut,
  output logic halfOut,
  output logic zeroOut,
  output logic updCarry,
  output logic updHalf,
  output logic updZero
);
  logic [7:0] minuend;
  logic [8:0] diffWide;
  logic [4:0] diffLow;

  // subtract by adding the complement: top bit set means no borrow
  assign minuend = (op == file_register_alu_pkg::OP_LITERAL_MINUS_ACC) ?
                   literal : fileVal; // RL6 RL7
  assign diffWide = {1'b0, minuend} + {1'b0, ~acc} + 9'h001; // RL12
  assign diffLow = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01; // RL12

  always_comb begin
    result = fileVal;
    carryOut = carryIn;
    halfOut = diffLow[`NIBBLE_CARRY_POS];
    updCarry = 1'b0;
    updHalf = 1'b0;
    updZero = 1'b0;
    case (op)
      file_register_alu_pkg::OP_INCREMENT_FILE: begin
        result = fileVal + `BYTE_ONE; // RL2
        updZero = 1'b1;
      end
      file_register_alu_pkg::OP_OR_INTO_FILE: begin
        result = acc | fileVal; // RL3
        updZero = 1'b1;
      end
      file_register_alu_pkg::OP_ROTATE_LEFT_CARRY: begin
        result = {fileVal[6:0], carryIn}; // RL4
        carryOut = fileVal[`MSB_POS];
        updCarry = 1'b1;
      end
      file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY: begin
        result = {carryIn, fileVal[7:1]}; // RL5
        carryOut = fileVal[0];
        updCarry = 1'b1;
      end
      file_register_alu_pkg::OP_LITERAL_MINUS_ACC,
      file_register_alu_pkg::OP_FILE_MINUS_ACC: begin
        result = diffWide[7:0]; // RL6 RL7
        carryOut = diffWide[`BYTE_CARRY_POS]; // RL12
        updCarry = 1'b1;
        updHalf = 1'b1;
        updZero = 1'b1;
      end
      default: begin
        result = fileVal;
      end
    endcase
  end

  assign zeroOut = (result == 8'h00);
endmodule // file_alu_core
`default_nettype wire

//--- verif/file_register_alu_ops_test.sv
// self-checking bench for the file-register datapath
`timescale 1ns/100ps
`default_nettype none
module file_register_alu_ops_test;
  logic mclk, rstn, opValid, destBit, wakeUp;
  file_register_alu_pkg::op_t op;
  logic [6:0] fileAddr, fileWrAddrR;
  logic [7:0] literal, fileRdData, accR, fileWrDataR, watchdogCountR;
  logic [12:0] stackHead, pcValueR;
  logic fileWrEnR, carryR, halfByteOverflowR, zeroR, powerdownFlagR;
  logic timeoutFlagR, pcLoadR, stackPopR, watchdogClearR, prescalerClearR;
  logic busyR, asleepR;
  // expected accumulator and flags, kept by the bench
  logic [7:0] accE;
  logic cE, dcE, zE;
  int errorCnt, nChecks;

  file_register_alu_ops i_file_register_alu_ops (
    .mclk(mclk), .rstn(rstn), .opValid(opValid), .op(op),
    .fileAddr(fileAddr), .destBit(destBit), .literal(literal),
    .fileRdData(fileRdData), .stackHead(stackHead), .wakeUp(wakeUp),
    .accR(accR), .fileWrEnR(fileWrEnR), .fileWrAddrR(fileWrAddrR),
    .fileWrDataR(fileWrDataR), .carryR(carryR),
    .halfByteOverflowR(halfByteOverflowR), .zeroR(zeroR),
    .powerdownFlagR(powerdownFlagR), .timeoutFlagR(timeoutFlagR),
    .pcLoadR(pcLoadR), .pcValueR(pcValueR), .stackPopR(stackPopR),
    .watchdogClearR(watchdogClearR), .watchdogCountR(watchdogCountR),
    .prescalerClearR(prescalerClearR), .busyR(busyR), .asleepR(asleepR)
  );

  always #5 mclk = ~mclk;

  task automatic endOfTest;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chkWord(input logic [12:0] got, input logic [12:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    chkWord({5'h00, got}, {5'h00, exp});
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkWord({12'h000, got}, {12'h000, exp});
  endtask

  task automatic chkFlags;
    chkByte(accR, accE);
    chkBit(carryR, cE);
    chkBit(halfByteOverflowR, dcE);
    chkBit(zeroR, zE);
  endtask

  // second call at the end of the run also proves the status bits come back
  task automatic doReset;
    @(negedge mclk);
    rstn = 1'b0;
    opValid = 1'b0;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    accE = 8'h00;
    {cE, dcE, zE} = 3'h0;
    chkFlags();
    chkBit(powerdownFlagR, 1'b1);
    chkBit(timeoutFlagR, 1'b1);
    chkBit(fileWrEnR, 1'b0);
    chkBit(pcLoadR, 1'b0);
    chkWord(pcValueR, 13'h0000);
    chkBit(busyR, 1'b0);
    chkBit(asleepR, 1'b0);
  endtask

  // called at a falling edge; drives, waits one cycle, judges
  task automatic alu(input file_register_alu_pkg::op_t o,
    input logic [6:0] a, input logic d, input logic [7:0] l,
    input logic [7:0] f);
    logic [7:0] res, src;
    logic [8:0] dif;
    logic [4:0] nib;
    logic toAcc;
    src = (o == file_register_alu_pkg::OP_LITERAL_MINUS_ACC) ? l : f;
    dif = {1'b0, src} + {1'b0, ~accE} + 9'h001;
    nib = {1'b0, src[3:0]} + {1'b0, ~accE[3:0]} + 5'h01;
    case (o)
      file_register_alu_pkg::OP_INCREMENT_FILE: res = f + 8'h01;
      file_register_alu_pkg::OP_OR_INTO_FILE: res = accE | f;
      file_register_alu_pkg::OP_ROTATE_LEFT_CARRY: begin
        res = {f[6:0], cE};
        cE = f[7];
      end
      file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res = {cE, f[7:1]};
        cE = f[0];
      end
      default: begin
        res = dif[7:0];
        cE = dif[8];
        dcE = nib[4];
      end
    endcase
    if (o != file_register_alu_pkg::OP_ROTATE_LEFT_CARRY &&
        o != file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY) zE = res == 8'h00;
    toAcc = !d || o == file_register_alu_pkg::OP_LITERAL_MINUS_ACC;
    opValid = 1'b1;
    op = o;
    fileAddr = a;
    destBit = d;
    literal = l;
    fileRdData = f;
    @(negedge mclk);
    if (toAcc) accE = res;
    chkFlags();
    chkBit(fileWrEnR, !toAcc);
    if (!toAcc) begin
      chkByte({1'b0, fileWrAddrR}, {1'b0, a});
      chkByte(fileWrDataR, res);
    end
  endtask

  task automatic retTest;
    op = file_register_alu_pkg::OP_SUBROUTINE_RETURN;
    opValid = 1'b1;
    stackHead = 13'h1ABC;
    @(negedge mclk);
    chkBit(pcLoadR, 1'b1);
    chkBit(stackPopR, 1'b1);
    chkWord(pcValueR, 13'h1ABC);
    chkBit(busyR, 1'b1);
    // offered in the tail cycle, must be dropped
    op = file_register_alu_pkg::OP_INCREMENT_FILE;
    fileRdData = 8'h55;
    destBit = 1'b0;
    stackHead = 13'h0000;
    @(negedge mclk);
    chkBit(pcLoadR, 1'b0);
    chkBit(stackPopR, 1'b0);
    chkBit(busyR, 1'b0);
    chkBit(fileWrEnR, 1'b0);
    chkFlags();
  endtask

  task automatic sleepTest;
    int i;
    op = file_register_alu_pkg::OP_SLEEP;
    opValid = 1'b1;
    @(negedge mclk);
    chkBit(powerdownFlagR, 1'b0);
    chkBit(timeoutFlagR, 1'b1);
    chkFlags();
    chkBit(watchdogClearR, 1'b1);
    chkBit(prescalerClearR, 1'b1);
    chkByte(watchdogCountR, 8'h00);
    chkBit(asleepR, 1'b1);
    op = file_register_alu_pkg::OP_INCREMENT_FILE;
    fileRdData = 8'h7E;
    destBit = 1'b0;
    repeat (3) @(negedge mclk);
    chkFlags();
    chkBit(fileWrEnR, 1'b0);
    chkBit(busyR, 1'b1);
    chkBit(watchdogClearR, 1'b0);
    opValid = 1'b0;
    wakeUp = 1'b1;
    for (i = 0; i < 4 && asleepR !== 1'b0; i++) @(negedge mclk);
    if (asleepR !== 1'b0) begin
      errorCnt++;
      endOfTest();
    end
    chkBit(busyR, 1'b0);
    wakeUp = 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    opValid = 1'b0;
    op = file_register_alu_pkg::OP_INCREMENT_FILE;
    {fileAddr, destBit, literal, fileRdData} = 24'h000000;
    stackHead = 13'h0000;
    wakeUp = 1'b0;
    errorCnt = 0;
    nChecks = 0;
    doReset();
    alu(file_register_alu_pkg::OP_INCREMENT_FILE,
        7'h7F, 1'b0, 8'h00, 8'hFF);
    alu(file_register_alu_pkg::OP_INCREMENT_FILE,
        7'h7F, 1'b1, 8'h00, 8'h41);
    alu(file_register_alu_pkg::OP_OR_INTO_FILE,
        7'h05, 1'b0, 8'h00, 8'h3C);
    alu(file_register_alu_pkg::OP_OR_INTO_FILE,
        7'h06, 1'b1, 8'h00, 8'h00);
    alu(file_register_alu_pkg::OP_ROTATE_LEFT_CARRY,
        7'h10, 1'b0, 8'h00, 8'h80);
    alu(file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY,
        7'h11, 1'b1, 8'h00, 8'h02);
    alu(file_register_alu_pkg::OP_LITERAL_MINUS_ACC,
        7'h00, 1'b1, 8'h10, 8'h00);
    alu(file_register_alu_pkg::OP_LITERAL_MINUS_ACC,
        7'h00, 1'b0, 8'h05, 8'h00);
    alu(file_register_alu_pkg::OP_FILE_MINUS_ACC,
        7'h20, 1'b1, 8'h00, 8'hF8);
    alu(file_register_alu_pkg::OP_FILE_MINUS_ACC,
        7'h22, 1'b0, 8'h00, 8'h13);
    alu(file_register_alu_pkg::OP_FILE_MINUS_ACC,
        7'h21, 1'b0, 8'h00, 8'h1E);
    retTest();
    alu(file_register_alu_pkg::OP_INCREMENT_FILE,
        7'h00, 1'b0, 8'h00, 8'h0F);
    sleepTest();
    alu(file_register_alu_pkg::OP_ROTATE_RIGHT_CARRY,
        7'h01, 1'b0, 8'h00, 8'h01);
    doReset();
    endOfTest();
  end
endmodule // file_register_alu_ops_test
`default_nettype wire
